// [src/basic_mode_control_register.sv]
// Basic mode control register with APB access and MAC path control
//
// Function
// - Writing one to the soft reset bit resets the digital logic and all low-range registers to defaults.
// - A soft reset leaves registers above the low sixteen indices untouched.
// - The soft reset bit is set only by writing one, ignores zero, clears itself and reads zero when idle.
// - With loopback set, MAC transmit data is returned to the MAC receive outputs.
// - No link-up indication is produced while loopback is on.
// - The speed bit is read-only and always reads one.
// - The auto-negotiation enable bit is read-only and reads zero.
// - With power down set, everything but register access is powered down.
// - Effective power down is the register bit ORed with the pin when the pin is configured for it.
// - While the low-active pin is low and configured for power down, the power-down bit reads as set.
// - With isolate set, the port is detached from the MAC data path while management stays usable.
// - The duplex bit is read-only and reads one for full duplex.
// - The register sits at index zero and resets to speed and duplex set only.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module basic_mode_control_register
#(
	parameter int SOFT_RESET_LEN = basic_mode_control_pkg::SOFT_RESET_CYCLES // Soft reset length in cycles
)
(
	input wire logic sys_clk_i, // 100 MHz clock
	input wire logic srst_i, // Sync reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [basic_mode_control_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [basic_mode_control_pkg::DATA_W-1:0] pwdata, // APB write data
	output logic [basic_mode_control_pkg::DATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic pwrdn_pin_n_i, // Low-active power-down pin
	input wire logic pin_pd_mode_i, // Pin configured for power down
	input wire basic_mode_control_pkg::mii_beat_s mac_tx_i, // Transmit beat from MAC
	input wire basic_mode_control_pkg::mii_beat_s line_rx_i, // Receive beat from line side
	input wire logic line_link_i, // Raw link status
	output basic_mode_control_pkg::mii_beat_s mac_rx_o, // Receive beat to MAC
	output basic_mode_control_pkg::mii_beat_s line_tx_o, // Transmit beat to line side
	output logic link_up_o, // Link-up indication
	output logic digital_reset_o, // Digital logic held in reset
	output logic power_down_o, // Effective power down
	output logic isolate_o, // Isolate active
	output logic loopback_o // Loopback active
);
	import basic_mode_control_pkg::*;

	localparam logic [SOFT_CNT_W-1:0] SOFT_LEN = SOFT_CNT_W'(SOFT_RESET_LEN);

	logic loopback_reg, loopback_next;
	logic pd_reg, pd_next;
	logic isolate_reg, isolate_next;
	logic spare_reg, spare_next;
	logic [REG_W-1:0] ext_scratch_reg, ext_scratch_next;
	logic [SOFT_CNT_W-1:0] soft_cnt_reg, soft_cnt_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;

	logic setup_phase;
	logic wr_commit;
	logic hit_basic_mode_control;
	logic hit_low;
	logic hit_ext;
	logic mapped;
	logic soft_active;
	logic pin_pd;
	logic pd_eff;
	logic [REG_W-1:0] basic_mode_control_view;

	assign setup_phase = psel & ~penable;
	assign wr_commit = psel & penable & pwrite;
	assign hit_basic_mode_control = (paddr == BASIC_MODE_CONTROL_ADDR);
	assign hit_low = (paddr[1:0] == 2'b00) && (paddr <= LOW_TOP_ADDR);
	assign hit_ext = (paddr == EXT_SCRATCH_ADDR);
	assign mapped = hit_low | hit_ext;
	assign soft_active = (soft_cnt_reg != SOFT_CNT_ZERO);

	assign pin_pd = pin_pd_mode_i & ~pwrdn_pin_n_i;
	assign pd_eff = pd_reg | pin_pd;

	always_comb
	begin
		basic_mode_control_view = '0;
		basic_mode_control_view[SOFT_RESET_BIT] = soft_active;
		basic_mode_control_view[LOOPBACK_BIT] = loopback_reg;
		basic_mode_control_view[SPEED_BIT] = SPEED_VALUE;
		basic_mode_control_view[AUTONEG_BIT] = AUTONEG_VALUE;
		basic_mode_control_view[POWER_DOWN_BIT] = pd_eff;
		basic_mode_control_view[ISOLATE_BIT] = isolate_reg;
		basic_mode_control_view[DUPLEX_BIT] = DUPLEX_VALUE;
		basic_mode_control_view[SPARE_BIT] = spare_reg;
	end

	always_comb
	begin
		loopback_next = loopback_reg;
		pd_next = pd_reg;
		isolate_next = isolate_reg;
		spare_next = spare_reg;
		ext_scratch_next = ext_scratch_reg;
		soft_cnt_next = soft_cnt_reg;
		rdata_next = rdata_reg;
		if (soft_active)
		begin
			soft_cnt_next = soft_cnt_reg - SOFT_CNT_ONE;
		end
		if (setup_phase)
		begin
			rdata_next = '0;
			if (hit_basic_mode_control)
			begin
				rdata_next[REG_W-1:0] = basic_mode_control_view;
			end
			else if (hit_ext)
			begin
				rdata_next[REG_W-1:0] = ext_scratch_reg;
			end
		end
		if (wr_commit && hit_basic_mode_control && !soft_active)
		begin
			loopback_next = pwdata[LOOPBACK_BIT];
			pd_next = pwdata[POWER_DOWN_BIT];
			isolate_next = pwdata[ISOLATE_BIT];
			spare_next = pwdata[SPARE_BIT];
			if (pwdata[SOFT_RESET_BIT])
			begin
				soft_cnt_next = SOFT_LEN;
			end
		end
		if (wr_commit && hit_ext)
		begin
			ext_scratch_next = pwdata[REG_W-1:0];
		end
		if (soft_cnt_next != SOFT_CNT_ZERO)
		begin
			loopback_next = BASIC_MODE_CONTROL_RESET[LOOPBACK_BIT];
			pd_next = BASIC_MODE_CONTROL_RESET[POWER_DOWN_BIT];
			isolate_next = BASIC_MODE_CONTROL_RESET[ISOLATE_BIT];
			spare_next = BASIC_MODE_CONTROL_RESET[SPARE_BIT];
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			loopback_reg <= BASIC_MODE_CONTROL_RESET[LOOPBACK_BIT];
			pd_reg <= BASIC_MODE_CONTROL_RESET[POWER_DOWN_BIT];
			isolate_reg <= BASIC_MODE_CONTROL_RESET[ISOLATE_BIT];
			spare_reg <= BASIC_MODE_CONTROL_RESET[SPARE_BIT];
			soft_cnt_reg <= SOFT_CNT_ZERO;
			rdata_reg <= '0;
		end
		else
		begin
			loopback_reg <= loopback_next;
			pd_reg <= pd_next;
			isolate_reg <= isolate_next;
			spare_reg <= spare_next;
			soft_cnt_reg <= soft_cnt_next;
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ext_scratch_reg <= EXT_SCRATCH_RESET;
		end
		else
		begin
			ext_scratch_reg <= ext_scratch_next;
		end
	end

	// Zero wait states; read data captured in setup
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = rdata_reg;

	assign digital_reset_o = soft_active;
	assign power_down_o = pd_eff;
	assign isolate_o = isolate_reg;
	assign loopback_o = loopback_reg;

	mac_path_ctrl mac_path_ctrl_inst
	(
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.hold_i(soft_active),
		.loopback_i(loopback_reg),
		.isolate_i(isolate_reg),
		.power_down_i(pd_eff),
		.mac_tx_i(mac_tx_i),
		.line_rx_i(line_rx_i),
		.line_link_i(line_link_i),
		.mac_rx_o(mac_rx_o),
		.line_tx_o(line_tx_o),
		.link_up_o(link_up_o)
	);
endmodule : basic_mode_control_register
`default_nettype wire

// [src/basic_mode_control_pkg.sv]
// Constants and types for the basic mode control register block
package basic_mode_control_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;
	// Register indices; byte address is four times the index
	localparam logic [5:0] BASIC_MODE_CONTROL_IDX = 6'h00;
	localparam logic [5:0] LOW_TOP_IDX = 6'h0F;
	localparam logic [5:0] EXT_SCRATCH_IDX = 6'h10;
	localparam logic [ADDR_W-1:0] BASIC_MODE_CONTROL_ADDR = {BASIC_MODE_CONTROL_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] LOW_TOP_ADDR = {LOW_TOP_IDX, 2'b00};
	localparam logic [ADDR_W-1:0] EXT_SCRATCH_ADDR = {EXT_SCRATCH_IDX, 2'b00};
	// Field positions
	localparam int SOFT_RESET_BIT = 15;
	localparam int LOOPBACK_BIT = 14;
	localparam int SPEED_BIT = 13;
	localparam int AUTONEG_BIT = 12;
	localparam int POWER_DOWN_BIT = 11;
	localparam int ISOLATE_BIT = 10;
	localparam int DUPLEX_BIT = 8;
	localparam int SPARE_BIT = 7;
	// Reset values
	localparam logic [REG_W-1:0] BASIC_MODE_CONTROL_RESET = 16'h2100;
	localparam logic [REG_W-1:0] EXT_SCRATCH_RESET = 16'h0000;
	localparam logic SPEED_VALUE = 1'b1;
	localparam logic AUTONEG_VALUE = 1'b0;
	localparam logic DUPLEX_VALUE = 1'b1;
	// Soft reset duration
	localparam int SOFT_RESET_NS = 160;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SOFT_CNT_W = 8;
	localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_ZERO = 8'h00;
	localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_ONE = 8'h01;
	// Nibble-wide media independent data beat
	typedef struct packed {
		logic [3:0] data;
		logic valid;
		logic err;
	} mii_beat_s;
	localparam mii_beat_s MII_IDLE = '{data: 4'h0, valid: 1'b0, err: 1'b0};
endpackage : basic_mode_control_pkg

// [src/mac_path_ctrl.sv]
// MAC-side data steering: loopback, isolate, power down, link gating
`timescale 1ns/1ps
`default_nettype none
module mac_path_ctrl
(
	input wire logic sys_clk_i, // 100 MHz clock
	input wire logic srst_i, // Sync reset, active high
	input wire logic hold_i, // Digital logic held in reset
	input wire logic loopback_i, // MAC-side loopback enable
	input wire logic isolate_i, // Isolate from MAC
	input wire logic power_down_i, // Effective power down
	input wire basic_mode_control_pkg::mii_beat_s mac_tx_i, // Transmit beat from MAC
	input wire basic_mode_control_pkg::mii_beat_s line_rx_i, // Receive beat from line side
	input wire logic line_link_i, // Raw link status from line side
	output basic_mode_control_pkg::mii_beat_s mac_rx_o, // Receive beat to MAC
	output basic_mode_control_pkg::mii_beat_s line_tx_o, // Transmit beat to line side
	output logic link_up_o // Link-up indication
);
	import basic_mode_control_pkg::*;

	mii_beat_s rx_reg, rx_next;
	mii_beat_s tx_reg, tx_next;
	logic link_reg, link_next;
	logic quiet;

	always_comb
	begin
		quiet = hold_i | power_down_i;
		rx_next = line_rx_i;
		tx_next = mac_tx_i;
		if (loopback_i)
		begin
			rx_next = mac_tx_i;
			tx_next = MII_IDLE;
		end
		if (isolate_i)
		begin
			rx_next = MII_IDLE;
			tx_next = MII_IDLE;
		end
		if (quiet)
		begin
			rx_next = MII_IDLE;
			tx_next = MII_IDLE;
		end
		link_next = line_link_i & ~loopback_i & ~quiet;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			rx_reg <= MII_IDLE;
			tx_reg <= MII_IDLE;
			link_reg <= 1'b0;
		end
		else
		begin
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			link_reg <= link_next;
		end
	end

	assign mac_rx_o = rx_reg;
	assign line_tx_o = tx_reg;
	assign link_up_o = link_reg;
endmodule : mac_path_ctrl
`default_nettype wire

// [test/basic_mode_control_asserts.sv]
// Assertions for the basic mode control register
`timescale 1ns/1ps
`default_nettype none
module basic_mode_control_asserts
import basic_mode_control_pkg::*;
#(
	parameter int SOFT_RESET_LEN = basic_mode_control_pkg::SOFT_RESET_CYCLES // Soft reset cycles
)
(
	input wire logic sys_clk_i, // Clock
	input wire logic srst_i, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Access
	input wire logic [basic_mode_control_pkg::ADDR_W-1:0] paddr, // Address
	input wire logic pslverr, // Error
	input wire logic pwrdn_pin_n_i, // Pin
	input wire logic pin_pd_mode_i, // Pin mode
	input wire basic_mode_control_pkg::mii_beat_s mac_tx_i, // Tx in
	input wire basic_mode_control_pkg::mii_beat_s mac_rx_o, // Rx out
	input wire basic_mode_control_pkg::mii_beat_s line_tx_o, // Tx out
	input wire logic link_up_o, // Link
	input wire logic digital_reset_o, // Soft reset
	input wire logic power_down_o, // Power down
	input wire logic isolate_o, // Isolate
	input wire logic loopback_o // Loopback
);
	localparam int LM1 = SOFT_RESET_LEN - 1;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	chk_pin_pd:
	assert property (pin_pd_mode_i && !pwrdn_pin_n_i |-> power_down_o) else $error("pin power down lost");
	chk_lb_link:
	assert property (loopback_o |=> !link_up_o) else $error("link up in loopback");
	chk_lb_path:
	assert property (loopback_o && !isolate_o && !power_down_o && !digital_reset_o
		|=> mac_rx_o == $past(mac_tx_i)) else $error("loopback data wrong");
	chk_iso_rx:
	assert property (isolate_o |=> mac_rx_o == MII_IDLE) else $error("rx not idle in isolate");
	chk_iso_tx:
	assert property (isolate_o |=> line_tx_o == MII_IDLE) else $error("tx not idle in isolate");
	chk_pd_tx:
	assert property (power_down_o |=> line_tx_o == MII_IDLE && !link_up_o) else $error("active in power down");
	chk_soft_len:
	assert property ($rose(digital_reset_o) |-> ##LM1 digital_reset_o ##1 !digital_reset_o)
		else $error("soft reset length wrong");
	chk_soft_link:
	assert property (digital_reset_o |=> !link_up_o) else $error("link up in soft reset");
	chk_map_err:
	assert property (psel && penable && paddr == 8'h44 |-> pslverr) else $error("no error on unmapped");
	cover property (loopback_o ##1 loopback_o);
	cover property ($rose(digital_reset_o));
	cover property (pslverr);
endmodule : basic_mode_control_asserts
bind basic_mode_control_register basic_mode_control_asserts #(.SOFT_RESET_LEN(SOFT_RESET_LEN)) basic_mode_control_asserts_inst (.sys_clk_i,
	.srst_i, .psel, .penable, .paddr, .pslverr, .pwrdn_pin_n_i, .pin_pd_mode_i, .mac_tx_i, .mac_rx_o,
	.line_tx_o, .link_up_o, .digital_reset_o, .power_down_o, .isolate_o, .loopback_o);
`default_nettype wire

// [test/tb_basic_mode_control_register.sv]
// Testbench for the basic mode control register
`timescale 1ns/1ps
`default_nettype none
module tb_basic_mode_control_register;
	import basic_mode_control_pkg::*;
	logic sys_clk_i = 0;
	logic srst_i = 1;
	logic psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata, q;
	logic pready, pslverr, e, pwrdn_pin_n_i = 1, pin_pd_mode_i = 0, line_link_i = 0;
	mii_beat_s mac_tx_i = MII_IDLE, line_rx_i = MII_IDLE, mac_rx_o, line_tx_o;
	logic link_up_o, digital_reset_o, power_down_o, isolate_o, loopback_o;
	int n_fail = 0, checked = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	basic_mode_control_register #(.SOFT_RESET_LEN(8)) basic_mode_control_register_inst (.sys_clk_i, .srst_i,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwrdn_pin_n_i, .pin_pd_mode_i,
		.mac_tx_i, .line_rx_i, .line_link_i, .mac_rx_o, .line_tx_o, .link_up_o, .digital_reset_o,
		.power_down_o, .isolate_o, .loopback_o);
	task close_out;
		if (n_fail == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task cmp_w(input string s, input logic [31:0] x, input logic [31:0] y);
		checked++;
		if (x !== y)
		begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", s, x, y);
		end
	endtask : cmp_w
	task cmp_b(input string s, input logic x, input logic y);
		cmp_w(s, {31'h0, x}, {31'h0, y});
	endtask : cmp_b
	// One APB transfer; result left in q and e
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1;
		do @(posedge sys_clk_i); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		cmp_w("prdata", x, q);
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : cyc
	task t_regs;
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2100);
		cmp_b("pslverr", 0, e);
		rd(EXT_SCRATCH_ADDR, 32'h0000_0000);
		apb(1, 8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0000_0000);
		cmp_b("pslverr", 0, e);
		rd(8'h44, 32'h0000_0000);
		cmp_b("pslverr", 1, e);
	endtask : t_regs
	task t_fields;
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'hFFFF_7FFF);
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_6D80);
		cmp_b("power_down_o", 1, power_down_o);
		cmp_b("isolate_o", 1, isolate_o);
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_0000);
		#1;
		cmp_b("digital_reset_o", 0, digital_reset_o);
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2100);
	endtask : t_fields
	task t_loop;
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_4000);
		line_link_i <= 1;
		line_rx_i <= 6'h15;
		mac_tx_i <= 6'h2A;
		cyc(3);
		cmp_w("mac_rx_o", 32'h0000_002A, {26'h0, mac_rx_o});
		cmp_b("link_up_o", 0, link_up_o);
		cmp_b("loopback_o", 1, loopback_o);
		cmp_w("line_tx_o", 32'h0000_0000, {26'h0, line_tx_o});
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_0000);
		cyc(3);
		cmp_w("mac_rx_o", 32'h0000_0015, {26'h0, mac_rx_o});
		cmp_b("link_up_o", 1, link_up_o);
		cmp_w("line_tx_o", 32'h0000_002A, {26'h0, line_tx_o});
	endtask : t_loop
	task t_iso;
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_0400);
		cyc(2);
		cmp_w("mac_rx_o", 32'h0000_0000, {26'h0, mac_rx_o});
		cmp_w("line_tx_o", 32'h0000_0000, {26'h0, line_tx_o});
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2500);
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_0000);
	endtask : t_iso
	task t_pin;
		pin_pd_mode_i <= 1;
		pwrdn_pin_n_i <= 0;
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2900);
		cmp_b("power_down_o", 1, power_down_o);
		cmp_b("link_up_o", 0, link_up_o);
		cmp_w("line_tx_o", 32'h0000_0000, {26'h0, line_tx_o});
		pin_pd_mode_i <= 0;
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2100);
		pwrdn_pin_n_i <= 1;
	endtask : t_pin
	task t_soft;
		apb(1, EXT_SCRATCH_ADDR, 32'h0000_A5A5);
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_4480);
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_8000);
		#1;
		cmp_b("digital_reset_o", 1, digital_reset_o);
		cmp_b("loopback_o", 0, loopback_o);
		// Read and write while the eight-cycle soft reset runs
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_A100);
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_4400);
		cyc(1);
		cmp_b("digital_reset_o", 1, digital_reset_o);
		cyc(1);
		cmp_b("digital_reset_o", 0, digital_reset_o);
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2100);
		rd(EXT_SCRATCH_ADDR, 32'h0000_A5A5);
	endtask : t_soft
	task t_srst;
		apb(1, BASIC_MODE_CONTROL_ADDR, 32'h0000_4C80);
		srst_i <= 1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 0;
		rd(BASIC_MODE_CONTROL_ADDR, 32'h0000_2100);
		rd(EXT_SCRATCH_ADDR, 32'h0000_0000);
		cmp_b("loopback_o", 0, loopback_o);
		cmp_b("power_down_o", 0, power_down_o);
		cmp_b("isolate_o", 0, isolate_o);
	endtask : t_srst
	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		srst_i <= 0;
		t_regs;
		t_fields;
		t_loop;
		t_iso;
		t_pin;
		t_soft;
		t_srst;
		close_out;
	end
	initial
	begin
		#20000;
		n_fail++;
		close_out;
	end
endmodule : tb_basic_mode_control_register
`default_nettype wire
